/* File: include/tpm_pkg.sv */
// constants, register layout and carrier types of the timer/pwm counter
// How it works
// RULE1 - combined pair outputs complementary or identical
// RULE2 - second channel shows idle level when stopped
// RULE3 - dead time zero off, else value times four
// RULE4 - swap picks odd input, else even input
// RULE5 - separate edge selection per channel of pair
// RULE6 - edges: rising, falling or both
// RULE7 - phase input filter, zero disables it
// RULE8 - each phase input may be inverted
// RULE9 - prescaler divides by one to 128
// RULE10 - clock from system, clock pin or trigger
// RULE11 - channels may use shared time base
// RULE12 - local counter may follow shared time base
// RULE13 - trigger selectable, internal or external source
// RULE14 - external trigger gets selectable polarity
// RULE15 - doze option pauses counter in doze
// RULE16 - debug option keeps counter running halted
// RULE17 - trigger may reload the counter
// RULE18 - counter may stop after overflow
// RULE19 - counter may wait for trigger to start
// RULE20 - counter holds while trigger stays asserted
// RULE21 - per channel polarity inverts input or output
// RULE22 - overflow sets flag, enabled flag raises interrupt
`default_nettype none
package tpm_pkg;
   localparam int CNT_W = 16;
   localparam int NCH = 4;
   localparam int NPAIR = 2;
   localparam int NPIN = 11;
   // synchronised pin bus layout
   localparam int PIN_CH = 0;
   localparam int PIN_TRG = 4;
   localparam int PIN_CLK = 8;
   localparam int PIN_PA = 9;
   // register byte offsets
   localparam logic [5:0] OFF_CTRL = 6'h00;
   localparam logic [5:0] OFF_STAT = 6'h04;
   localparam logic [5:0] OFF_MOD = 6'h08;
   localparam logic [5:0] OFF_CNT = 6'h0c;
   localparam logic [5:0] OFF_PAIR = 6'h10;
   localparam logic [5:0] OFF_POLARITY = 6'h14;
   localparam logic [5:0] OFF_QUAD = 6'h18;
   localparam logic [5:0] OFF_CV0 = 6'h1c;
   localparam logic [5:0] CV_STEP = 6'h04;
   // status bit positions
   localparam int STAT_OVF = 0;
   localparam int STAT_CH = 1;
   localparam logic [CNT_W-1:0] MOD_RST = 16'hffff;
   localparam logic [CNT_W-1:0] RELOAD_VAL = 16'h0000;
   localparam logic [1:0] DEAD_SHIFT0 = 2'h0;
   localparam logic [1:0] CLK_SYS = 2'h0;
   localparam logic [1:0] CLK_PIN = 2'h1;
   localparam logic [1:0] CLK_TRIG = 2'h2;
   typedef enum logic [1:0] {
      EDGE_NONE = 2'h0,
      EDGE_RISE = 2'h1,
      EDGE_FALL = 2'h2,
      EDGE_BOTH = 2'h3
   } edge_t;
   typedef struct packed {
      logic [12:0] rsvd;
      logic ovf_irq_en;
      logic trig_invert;
      logic trig_external;
      logic [1:0] trig_select;
      logic shared_time_base_sync;
      logic shared_time_base_select;
      logic trigger_pause;
      logic trigger_start;
      logic overflow_halt;
      logic trigger_reload;
      logic debug_run;
      logic doze_pause;
      logic [2:0] prescale;
      logic [1:0] clk_source;
      logic enable;
   } ctrl_t;
   typedef struct packed {
      edge_t edge_hi;
      edge_t edge_lo;
      logic [3:0] dead_time_count;
      logic [2:0] rsvd;
      logic capture_input_swap;
      logic second_channel_idle_level;
      logic pair_inverted_outputs;
      logic dual_capture;
      logic combined_pwm;
   } pair_t;
   typedef struct packed {
      logic [24:0] rsvd;
      logic [1:0] phase_invert;
      logic [3:0] phase_filter_length;
      logic quad_enable;
   } quad_t;
endpackage
`default_nettype wire

/* File: hdl/timer_pwm_counter_control.sv */
// timer/pwm counter with combined pairs, dual-edge capture and quadrature decode
//
// The address map and the plain strobed port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module timer_pwm_counter_control (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic rstn_i,
   // register port
   input wire logic [5:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [31:0] rdata_o,
   // channel pins
   input wire logic [3:0] ch_in_i,
   output logic [3:0] ch_out_o,
   // clock, trigger and phase pins
   input wire logic external_counter_clock_pin_i,
   input wire logic [3:0] ext_trig_i,
   input wire logic [3:0] int_trig_i,
   input wire logic phase_a_i,
   input wire logic phase_b_i,
   // system
   input wire logic [15:0] global_tb_i,
   input wire logic doze_i,
   input wire logic debug_i,
   output logic irq_o,
   output logic ovf_dma_o
);
   tpm_pkg::ctrl_t ctrl_q;
   tpm_pkg::pair_t [1:0] pair_q;
   tpm_pkg::quad_t quad_q;
   logic [3:0] channel_polarity_register_q;
   logic [15:0] mod_q, cnt_q;
   logic [15:0] cv_q [4];
   logic [3:0] chf_q;
   logic ovf_flag_q, irq_q, dma_q, started_q, halted_q, trig_prev_q, run_q;
   logic [6:0] psc_q;
   logic [31:0] rdata_q;
   logic [3:0] ch_out_q;
   logic [10:0] pin_bus, s1_q, s2_q, s3_q, stab_q, prev_q;
   logic [1:0] flt_q, flt_prev_q;
   logic [3:0] cap, out_raw;
   logic [15:0] tb;
   logic trig_lvl, trig_edge, src_edge, tick, step, down, run, ovf;
   logic [6:0] psc_mask;
   logic wr_stat;

   // pin inputs: three flops, a change counts once the last two agree
   assign pin_bus = {phase_b_i, phase_a_i, external_counter_clock_pin_i, ext_trig_i, ch_in_i};
   for (genvar i = 0; i < tpm_pkg::NPIN; i++) begin : g_sync
      always_ff @(posedge clk_sys_i or negedge rstn_i) begin
         if (!rstn_i) begin
            s1_q[i] <= 1'b0;
            s2_q[i] <= 1'b0;
            s3_q[i] <= 1'b0;
            stab_q[i] <= 1'b0;
            prev_q[i] <= 1'b0;
         end else begin
            s1_q[i] <= pin_bus[i];
            s2_q[i] <= s1_q[i];
            s3_q[i] <= s2_q[i];
            if (s2_q[i] == s3_q[i]) begin
               stab_q[i] <= s3_q[i];
            end
            prev_q[i] <= stab_q[i];
         end
      end
   end

   // phase filter: a new level must persist for the filter length
   for (genvar j = 0; j < 2; j++) begin : g_phase
      logic [3:0] fcnt_q;
      logic raw;
      assign raw = stab_q[tpm_pkg::PIN_PA+j] ^ quad_q.phase_invert[j]; // see RULE8
      always_ff @(posedge clk_sys_i or negedge rstn_i) begin
         if (!rstn_i) begin
            flt_q[j] <= 1'b0;
            flt_prev_q[j] <= 1'b0;
            fcnt_q <= 4'h0;
         end else begin
            flt_prev_q[j] <= flt_q[j];
            if (quad_q.phase_filter_length == 4'h0 || raw == flt_q[j]) begin // see RULE7
               flt_q[j] <= raw;
               fcnt_q <= 4'h0;
            end else if (fcnt_q + 4'h1 >= quad_q.phase_filter_length) begin
               flt_q[j] <= raw;
               fcnt_q <= 4'h0;
            end else begin
               fcnt_q <= fcnt_q + 4'h1;
            end
         end
      end
   end

   // trigger selection and counter clock source
   always_comb begin
      if (ctrl_q.trig_external) begin // see RULE13
         trig_lvl = stab_q[tpm_pkg::PIN_TRG + int'(ctrl_q.trig_select)] ^ ctrl_q.trig_invert; // see RULE14
      end else begin
         trig_lvl = int_trig_i[ctrl_q.trig_select];
      end
   end
   assign trig_edge = trig_lvl & ~trig_prev_q;
   always_comb begin
      unique case (ctrl_q.clk_source) // see RULE10
         tpm_pkg::CLK_SYS: src_edge = 1'b1;
         tpm_pkg::CLK_PIN: src_edge = stab_q[tpm_pkg::PIN_CLK] & ~prev_q[tpm_pkg::PIN_CLK];
         tpm_pkg::CLK_TRIG: src_edge = trig_edge;
         default: src_edge = 1'b0;
      endcase
   end
   assign psc_mask = 7'((8'h01 << ctrl_q.prescale) - 8'h01);
   assign tick = src_edge && ((psc_q & psc_mask) == psc_mask); // see RULE9
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         psc_q <= 7'h00;
      end else if (!ctrl_q.enable || tick) begin
         psc_q <= 7'h00;
      end else if (src_edge) begin
         psc_q <= psc_q + 7'h01;
      end
   end

   // run gating
   assign run = ctrl_q.enable && started_q && !halted_q
      && !(ctrl_q.doze_pause && doze_i) // see RULE15
      && !(!ctrl_q.debug_run && debug_i) // see RULE16
      && !(ctrl_q.trigger_pause && trig_lvl); // see RULE20
   assign down = quad_q.quad_enable && flt_q[1];
   assign step = quad_q.quad_enable ? (flt_q[0] & ~flt_prev_q[0]) : tick;
   assign ovf = run && step && (down ? (cnt_q == 16'h0000) : (cnt_q == mod_q));
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         started_q <= 1'b0;
         halted_q <= 1'b0;
         trig_prev_q <= 1'b0;
         run_q <= 1'b0;
      end else begin
         trig_prev_q <= trig_lvl;
         run_q <= run;
         if (!ctrl_q.enable) begin
            started_q <= 1'b0;
         end else if (!ctrl_q.trigger_start || trig_edge) begin // see RULE19
            started_q <= 1'b1;
         end
         if (!ctrl_q.enable) begin
            halted_q <= 1'b0;
         end else if (ovf && ctrl_q.overflow_halt) begin // see RULE18
            halted_q <= 1'b1;
         end
      end
   end

   // local counter
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cnt_q <= tpm_pkg::RELOAD_VAL;
      end else if (!ctrl_q.enable) begin
         cnt_q <= tpm_pkg::RELOAD_VAL;
      end else if (ctrl_q.trigger_reload && trig_edge) begin // see RULE17
         cnt_q <= tpm_pkg::RELOAD_VAL;
      end else if (run && step) begin
         if (ctrl_q.shared_time_base_sync) begin // see RULE12
            cnt_q <= global_tb_i;
         end else if (down) begin
            cnt_q <= (cnt_q == 16'h0000) ? mod_q : cnt_q - 16'h0001;
         end else begin
            cnt_q <= (cnt_q == mod_q) ? tpm_pkg::RELOAD_VAL : cnt_q + 16'h0001;
         end
      end
   end
   assign tb = ctrl_q.shared_time_base_select ? global_tb_i : cnt_q; // see RULE11

   // overflow flag, interrupt and dma request; a new overflow beats the clear
   assign wr_stat = wr_i && addr_i == tpm_pkg::OFF_STAT;
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ovf_flag_q <= 1'b0;
         irq_q <= 1'b0;
         dma_q <= 1'b0;
      end else begin
         ovf_flag_q <= ovf || (ovf_flag_q && !(wr_stat && wdata_i[tpm_pkg::STAT_OVF])); // see RULE22
         irq_q <= (ovf || ovf_flag_q) && ctrl_q.ovf_irq_en; // see RULE22
         dma_q <= ovf; // see RULE22
      end
   end

   // per pair: pwm with dead time, or dual-edge capture
   for (genvar p = 0; p < tpm_pkg::NPAIR; p++) begin : g_pair
      localparam int LO = 2 * p;
      localparam int HI = 2 * p + 1;
      logic raw_q, sel_in, sel_prev, rise, fall, dead;
      logic [5:0] dt_q;
      logic [15:0] cv_lo, cv_hi;
      assign cv_lo = cv_q[LO];
      assign cv_hi = cv_q[HI];
      always_ff @(posedge clk_sys_i or negedge rstn_i) begin
         if (!rstn_i) begin
            raw_q <= 1'b0;
            dt_q <= 6'h00;
         end else begin
            raw_q <= (tb >= cv_lo) && (tb < cv_hi);
            if (raw_q != ((tb >= cv_lo) && (tb < cv_hi))) begin
               dt_q <= {pair_q[p].dead_time_count, tpm_pkg::DEAD_SHIFT0}; // see RULE3
            end else if (tick && dt_q != 6'h00) begin
               dt_q <= dt_q - 6'h01;
            end
         end
      end
      // zero dead time never blanks: dt_q only loads a zero then
      assign dead = pair_q[p].pair_inverted_outputs && dt_q != 6'h00; // see RULE3
      always_comb begin
         out_raw[LO] = 1'b0;
         out_raw[HI] = 1'b0;
         if (pair_q[p].combined_pwm) begin
            if (!run_q) begin
               out_raw[LO] = 1'b0;
               out_raw[HI] = pair_q[p].second_channel_idle_level; // see RULE2
            end else begin
               out_raw[LO] = raw_q && !dead;
               out_raw[HI] = (pair_q[p].pair_inverted_outputs ? ~raw_q : raw_q) && !dead; // see RULE1
            end
         end else if (!pair_q[p].dual_capture) begin
            out_raw[LO] = run_q && (tb < cv_lo);
            out_raw[HI] = run_q && (tb < cv_hi);
         end
      end
      // capture input after channel polarity
      assign sel_in = pair_q[p].capture_input_swap ? // see RULE4
         stab_q[tpm_pkg::PIN_CH+HI] ^ channel_polarity_register_q[HI] :
         stab_q[tpm_pkg::PIN_CH+LO] ^ channel_polarity_register_q[LO]; // see RULE21
      assign sel_prev = pair_q[p].capture_input_swap ?
         prev_q[tpm_pkg::PIN_CH+HI] ^ channel_polarity_register_q[HI] :
         prev_q[tpm_pkg::PIN_CH+LO] ^ channel_polarity_register_q[LO];
      assign rise = sel_in & ~sel_prev;
      assign fall = ~sel_in & sel_prev;
      assign cap[LO] = pair_q[p].dual_capture && ctrl_q.enable && // see RULE5
         ((pair_q[p].edge_lo[0] && rise) || (pair_q[p].edge_lo[1] && fall)); // see RULE6
      assign cap[HI] = pair_q[p].dual_capture && ctrl_q.enable &&
         ((pair_q[p].edge_hi[0] && rise) || (pair_q[p].edge_hi[1] && fall)); // see RULE6
   end

   // channel values and flags; capture beats a software write or clear
   for (genvar c = 0; c < tpm_pkg::NCH; c++) begin : g_ch
      always_ff @(posedge clk_sys_i or negedge rstn_i) begin
         if (!rstn_i) begin
            cv_q[c] <= 16'h0000;
            chf_q[c] <= 1'b0;
            ch_out_q[c] <= 1'b0;
         end else begin
            if (cap[c]) begin
               cv_q[c] <= tb;
            end else if (wr_i && addr_i == tpm_pkg::OFF_CV0 + 6'(c) * tpm_pkg::CV_STEP) begin
               cv_q[c] <= wdata_i[15:0];
            end
            chf_q[c] <= cap[c] || (chf_q[c] && !(wr_stat && wdata_i[tpm_pkg::STAT_CH+c]));
            ch_out_q[c] <= out_raw[c] ^ channel_polarity_register_q[c]; // see RULE21
         end
      end
   end

   // register writes
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ctrl_q <= '0;
         pair_q <= '0;
         quad_q <= '0;
         channel_polarity_register_q <= 4'h0;
         mod_q <= tpm_pkg::MOD_RST;
      end else if (wr_i) begin
         unique case (addr_i)
            tpm_pkg::OFF_CTRL: ctrl_q <= tpm_pkg::ctrl_t'({13'h0000, wdata_i[18:0]});
            tpm_pkg::OFF_MOD: mod_q <= wdata_i[15:0];
            tpm_pkg::OFF_PAIR: pair_q <= {wdata_i[31:24], 3'h0, wdata_i[20:8], 3'h0, wdata_i[4:0]};
            tpm_pkg::OFF_POLARITY: channel_polarity_register_q <= wdata_i[3:0];
            tpm_pkg::OFF_QUAD: quad_q <= tpm_pkg::quad_t'({25'h0000000, wdata_i[6:0]});
            default: ;
         endcase
      end
   end

   // register reads, data one cycle after the strobe
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rdata_q <= 32'h00000000;
      end else if (rd_i) begin
         unique case (addr_i)
            tpm_pkg::OFF_CTRL: rdata_q <= ctrl_q;
            tpm_pkg::OFF_STAT: rdata_q <= {27'h0000000, chf_q, ovf_flag_q};
            tpm_pkg::OFF_MOD: rdata_q <= {16'h0000, mod_q};
            tpm_pkg::OFF_CNT: rdata_q <= {16'h0000, cnt_q};
            tpm_pkg::OFF_PAIR: rdata_q <= pair_q;
            tpm_pkg::OFF_POLARITY: rdata_q <= {28'h0000000, channel_polarity_register_q};
            tpm_pkg::OFF_QUAD: rdata_q <= quad_q;
            tpm_pkg::OFF_CV0: rdata_q <= {16'h0000, cv_q[0]};
            tpm_pkg::OFF_CV0 + tpm_pkg::CV_STEP: rdata_q <= {16'h0000, cv_q[1]};
            tpm_pkg::OFF_CV0 + 6'h2 * tpm_pkg::CV_STEP: rdata_q <= {16'h0000, cv_q[2]};
            tpm_pkg::OFF_CV0 + 6'h3 * tpm_pkg::CV_STEP: rdata_q <= {16'h0000, cv_q[3]};
            default: rdata_q <= 32'h00000000;
         endcase
      end else begin
         rdata_q <= 32'h00000000;
      end
   end

   assign rdata_o = rdata_q;
   assign ch_out_o = ch_out_q;
   assign irq_o = irq_q;
   assign ovf_dma_o = dma_q;

   // checks
   ovf_flag_set_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // see RULE22
      ovf |=> ovf_flag_q && dma_q) else $error("overflow did not set flag");
   irq_follow_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // see RULE22
      ovf_flag_q && ctrl_q.ovf_irq_en && $stable(ctrl_q) |=> irq_q) else $error("interrupt missing");
   halt_hold_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // see RULE18
      halted_q && ctrl_q.enable && !(ctrl_q.trigger_reload && trig_edge) |=> $stable(cnt_q))
      else $error("counter moved after halt");
   reload_trig_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // see RULE17
      ctrl_q.enable && ctrl_q.trigger_reload && trig_edge |=> cnt_q == tpm_pkg::RELOAD_VAL)
      else $error("trigger did not reload");
   doze_hold_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // see RULE15
      ctrl_q.enable && ctrl_q.doze_pause && doze_i && !trig_edge |=> $stable(cnt_q))
      else $error("counter ran in doze");
   debug_hold_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // see RULE16
      ctrl_q.enable && !ctrl_q.debug_run && debug_i && !trig_edge |=> $stable(cnt_q))
      else $error("counter ran in debug");
   start_wait_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // see RULE19
      ctrl_q.trigger_start && !started_q && !trig_edge |=> !started_q || !ctrl_q.enable)
      else $error("started without trigger");
   idle_level_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // see RULE2
      pair_q[0].combined_pwm && !run_q
      |=> ch_out_q[1] == ($past(pair_q[0].second_channel_idle_level) ^ $past(channel_polarity_register_q[1])))
      else $error("idle level wrong");
   comp_pair_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // see RULE1
      pair_q[0].combined_pwm && pair_q[0].pair_inverted_outputs && run_q && !g_pair[0].dead
      && $stable(pair_q) && $stable(channel_polarity_register_q) && channel_polarity_register_q[1:0] == 2'h0
      |=> ch_out_q[0] != ch_out_q[1]) else $error("pair not complementary");
   ovf_cov_c: cover property (@(posedge clk_sys_i) disable iff (!rstn_i) ovf ##1 irq_q);
   cap_cov_c: cover property (@(posedge clk_sys_i) disable iff (!rstn_i) cap[0] ##[1:20] cap[1]);
   dead_cov_c: cover property (@(posedge clk_sys_i) disable iff (!rstn_i) g_pair[0].dead ##1 !g_pair[0].dead);
endmodule // timer_pwm_counter_control
`default_nettype wire

/* File: bench/tpm_far_side.sv */
// far-side model: trigger sources, pin clock, shared time base, capture and phase pins
`timescale 1ns/10ps
`default_nettype none
module tpm_far_side (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic rstn_i,
   // scenario control
   input wire logic clk_run_i,
   input wire logic trig_toggle_i,
   input wire logic trig_level_i,
   input wire logic [15:0] tb_value_i,
   // pins toward the block
   output logic [3:0] ch_in_o,
   output logic ext_clk_o,
   output logic [3:0] ext_trig_o,
   output logic [3:0] int_trig_o,
   output logic phase_a_o,
   output logic phase_b_o,
   output logic [15:0] global_tb_o
);
   logic [2:0] div_q;
   logic trig;
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         div_q <= 3'h0;
      end else begin
         div_q <= div_q + 3'h1;
      end
   end
   // pin clock stands still unless asked for; period eight cycles
   assign ext_clk_o = clk_run_i & div_q[2];
   // toggling gives a fresh rising edge every four cycles
   assign trig = trig_toggle_i ? div_q[1] : trig_level_i;
   assign ext_trig_o = {4{trig}};
   assign int_trig_o = {4{trig}};
   // only channel 1 and phase a follow the pin clock, so swap and direction show
   assign ch_in_o = {2'h0, ext_clk_o, 1'b0};
   assign phase_a_o = ext_clk_o;
   assign phase_b_o = 1'b0;
   assign global_tb_o = tb_value_i;
endmodule // tpm_far_side
`default_nettype wire

/* File: bench/timer_pwm_counter_control_tb.sv */
// self-checking bench for the timer/pwm counter
`timescale 1ns/10ps
`default_nettype none
module timer_pwm_counter_control_tb;
   logic clk_sys_i = 1'b0;
   logic rstn_i = 1'b0;
   logic [5:0] addr_i = 6'h00;
   logic [31:0] wdata_i = 32'h0;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic doze_i = 1'b0;
   logic debug_i = 1'b0;
   logic clk_run = 1'b0;
   logic trig_toggle = 1'b0;
   logic trig_level = 1'b0;
   logic [15:0] tb_value = 16'h0;
   logic [31:0] rdata_o;
   logic [3:0] ch_in, ch_out_o, ext_trig, int_trig;
   logic ext_clk, phase_a, phase_b, irq_o, ovf_dma_o;
   logic [15:0] global_tb;
   logic rd_pend = 1'b0;
   logic [63:0] exp_q[$];
   logic [63:0] note;
   logic [31:0] seed = 32'h09abd8a8;
   logic [31:0] r;
   int n_mismatch = 0;
   int cmp_count = 0;
   int g, lo, hi, same;

   always #20 clk_sys_i = ~clk_sys_i;

   timer_pwm_counter_control u_dut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .ch_in_i(ch_in),
      .ch_out_o(ch_out_o), .external_counter_clock_pin_i(ext_clk), .ext_trig_i(ext_trig),
      .int_trig_i(int_trig), .phase_a_i(phase_a), .phase_b_i(phase_b), .global_tb_i(global_tb),
      .doze_i(doze_i), .debug_i(debug_i), .irq_o(irq_o), .ovf_dma_o(ovf_dma_o));

   tpm_far_side u_far (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .clk_run_i(clk_run),
      .trig_toggle_i(trig_toggle), .trig_level_i(trig_level), .tb_value_i(tb_value),
      .ch_in_o(ch_in), .ext_clk_o(ext_clk), .ext_trig_o(ext_trig), .int_trig_o(int_trig),
      .phase_a_o(phase_a), .phase_b_o(phase_b), .global_tb_o(global_tb));

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   // one strobe per call; reads leave their expectation in the queue
   task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d, input logic [31:0] m);
      @(posedge clk_sys_i);
      wr_i <= w;
      rd_i <= !w;
      addr_i <= a;
      wdata_i <= d;
      if (!w) exp_q.push_back({d, m});
      @(posedge clk_sys_i);
      wr_i <= 1'b0;
      rd_i <= 1'b0;
   endtask

   always @(posedge clk_sys_i) rd_pend <= rd_i;
   always @(negedge clk_sys_i) begin
      if (rd_pend) begin
         note = exp_q.pop_front();
         cmp(rdata_o & note[31:0], note[63:32] & note[31:0], "read data");
      end
   end

   // stop first so every scenario starts from a stopped counter
   task automatic cfg(input logic [31:0] v);
      bus(1'b1, tpm_pkg::OFF_CTRL, 32'h0, 32'h0);
      bus(1'b1, tpm_pkg::OFF_CTRL, v, 32'h0);
   endtask

   task automatic gap(output int n);
      int w;
      w = 0;
      n = 0;
      do begin @(negedge clk_sys_i); w++; end while (ovf_dma_o !== 1'b1 && w < 3000);
      do begin @(negedge clk_sys_i); n++; end while (ovf_dma_o !== 1'b1 && n < 3000);
      if (w >= 3000 || n >= 3000) begin
         n_mismatch++;
         $display("ERROR %0t overflow pulse missing", $time);
         end_sim();
      end
      @(posedge clk_sys_i);
   endtask

   task automatic pulses(input int len, output int n);
      n = 0;
      repeat (len) begin
         @(negedge clk_sys_i);
         if (ovf_dma_o === 1'b1) n++;
      end
      @(posedge clk_sys_i);
   endtask

   task automatic watch(input int len, output int l, output int h, output int s);
      l = 0;
      h = 0;
      s = 0;
      repeat (len) begin
         @(negedge clk_sys_i);
         if (ch_out_o[0] === 1'b1) l++;
         if (ch_out_o[1] === 1'b1) h++;
         if (ch_out_o[1] === ch_out_o[0]) s++;
      end
   endtask

   initial begin
      repeat (3) @(posedge clk_sys_i);
      rstn_i <= 1'b1;
      bus(1'b0, tpm_pkg::OFF_CTRL, 32'h0, 32'hffffffff);
      bus(1'b0, tpm_pkg::OFF_MOD, 32'h0000ffff, 32'hffffffff);
      bus(1'b0, 6'h3c, 32'h0, 32'hffffffff);
      r = rnd();
      bus(1'b1, tpm_pkg::OFF_POLARITY, r, 32'h0);
      bus(1'b0, tpm_pkg::OFF_POLARITY, r & 32'hf, 32'hffffffff);
      bus(1'b1, tpm_pkg::OFF_MOD, 32'h9, 32'h0);
      for (int p = 0; p < 8; p++) begin
         cfg(32'h1 | 32'(p << 3));
         gap(g);
         cmp(32'(g), 32'(10 << p), "prescaled period");
      end
      clk_run <= 1'b1;
      cfg(32'h3);
      gap(g);
      cmp(32'(g), 32'd80, "pin clock period");
      // down count underflows at the first phase edge; a long filter swallows every edge
      for (int q = 0; q < 3; q++) begin
         bus(1'b1, tpm_pkg::OFF_QUAD, (q == 0) ? 32'h41 : (q == 1) ? 32'h1 : 32'h1f, 32'h0);
         cfg(32'h1);
         pulses((q == 2) ? 100 : 30, g);
         cmp(32'(g), (q == 0) ? 32'd1 : 32'd0, "quadrature count");
      end
      bus(1'b1, tpm_pkg::OFF_QUAD, 32'h0, 32'h0);
      for (int k = 0; k < 3; k++) begin
         bus(1'b1, tpm_pkg::OFF_PAIR, (k == 0) ? 32'h1012 : (k == 1) ? 32'hf002 : 32'h4012, 32'h0);
         bus(1'b1, tpm_pkg::OFF_STAT, 32'h1e, 32'h0);
         repeat (20) @(negedge clk_sys_i);
         bus(1'b0, tpm_pkg::OFF_STAT, (k == 0) ? 32'h2 : (k == 1) ? 32'h0 : 32'h4, 32'h6);
      end
      clk_run <= 1'b0;
      trig_toggle <= 1'b1;
      cfg(32'h10005);
      gap(g);
      cmp(32'(g), 32'd40, "trigger clock period");
      trig_toggle <= 1'b0;
      doze_i <= 1'b1;
      cfg(32'h41);
      pulses(40, g);
      cmp(32'(g), 32'd0, "doze pause");
      cfg(32'h1);
      gap(g);
      cmp(32'(g), 32'd10, "doze run");
      doze_i <= 1'b0;
      debug_i <= 1'b1;
      cfg(32'h1);
      pulses(40, g);
      cmp(32'(g), 32'd0, "debug pause");
      cfg(32'h81);
      gap(g);
      cmp(32'(g), 32'd10, "debug run");
      debug_i <= 1'b0;
      cfg(32'h40201);
      pulses(40, g);
      cmp(32'(g), 32'd1, "halt after overflow");
      cmp(32'(irq_o), 32'd1, "irq raised");
      bus(1'b0, tpm_pkg::OFF_STAT, 32'h1, 32'h1);
      bus(1'b1, tpm_pkg::OFF_STAT, 32'h1, 32'h0);
      repeat (2) @(negedge clk_sys_i);
      cmp(32'(irq_o), 32'd0, "irq cleared");
      bus(1'b0, tpm_pkg::OFF_STAT, 32'h0, 32'h1);
      cfg(32'h8401);
      pulses(40, g);
      cmp(32'(g), 32'd0, "waiting for start");
      trig_level <= 1'b1;
      gap(g);
      cmp(32'(g), 32'd10, "started");
      cfg(32'h8801);
      pulses(40, g);
      cmp(32'(g), 32'd0, "trigger held");
      trig_level <= 1'b0;
      gap(g);
      cmp(32'(g), 32'd10, "trigger released");
      cfg(32'h38801);
      pulses(40, g);
      cmp(32'(g), 32'd0, "inverted trigger held");
      trig_level <= 1'b1;
      gap(g);
      cmp(32'(g), 32'd10, "inverted trigger released");
      trig_toggle <= 1'b1;
      cfg(32'h8101);
      pulses(60, g);
      cmp(32'(g), 32'd0, "reloaded by trigger");
      cfg(32'h8001);
      gap(g);
      cmp(32'(g), 32'd10, "trigger ignored");
      trig_toggle <= 1'b0;
      tb_value <= 16'(rnd() & 32'h7);
      cfg(32'h2001);
      pulses(40, g);
      cmp(32'(g), 32'd0, "counter follows time base");
      cfg(32'h1001);
      gap(g);
      cmp(32'(g), 32'd10, "local overflow kept");
      cfg(32'h0);
      bus(1'b1, tpm_pkg::OFF_POLARITY, 32'h0, 32'h0);
      bus(1'b1, tpm_pkg::OFF_PAIR, 32'hd, 32'h0);
      repeat (5) @(negedge clk_sys_i);
      cmp(32'(ch_out_o[1:0]), 32'h2, "idle levels");
      bus(1'b1, tpm_pkg::OFF_POLARITY, 32'h1, 32'h0);
      repeat (5) @(negedge clk_sys_i);
      cmp(32'(ch_out_o[1:0]), 32'h3, "inverted idle");
      bus(1'b1, tpm_pkg::OFF_POLARITY, 32'h0, 32'h0);
      bus(1'b1, tpm_pkg::OFF_MOD, 32'h13, 32'h0);
      bus(1'b1, tpm_pkg::OFF_CV0, 32'h5, 32'h0);
      bus(1'b1, tpm_pkg::OFF_CV0 + tpm_pkg::CV_STEP, 32'hf, 32'h0);
      // three pair settings: complementary, identical, complementary with dead time
      for (int m = 0; m < 3; m++) begin
         r = (m == 0) ? 32'h5 : (m == 1) ? 32'h1 : 32'h105;
         bus(1'b1, tpm_pkg::OFF_PAIR, r, 32'h0);
         cfg(32'h1);
         pulses(25, g);
         watch(40, lo, hi, same);
         cmp(32'(lo), (m == 2) ? 32'd12 : 32'd20, "low channel high time");
         cmp(32'(hi), (m == 2) ? 32'd12 : 32'd20, "high channel high time");
         cmp(32'(same), (m == 0) ? 32'd0 : (m == 1) ? 32'd40 : 32'd16, "pair relation");
      end
      end_sim();
   end
endmodule // timer_pwm_counter_control_tb
`default_nettype wire
